//--- rtl/wtp_pkg.sv
package wtp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WTP_WORD_W = 16;
  localparam int WTP_ADDR_W = 16;
  localparam int WTP_LEN_W = 8;

  // ----------------------------------------------------------------
  // Table constants
  // ----------------------------------------------------------------
  localparam logic [WTP_WORD_W-1:0] WTP_PTR_WRAP = 16'h0001;
  localparam logic [WTP_WORD_W-1:0] WTP_STEP = 16'h0001;
  localparam logic [WTP_WORD_W-1:0] WTP_ZERO = 16'h0000;
  localparam logic [WTP_ADDR_W-1:0] WTP_FIRST_SLOT = 16'h0001;
  localparam logic [WTP_ADDR_W-1:0] WTP_ADDR_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic {
    WTP_STORE_INTO_TABLE_OP = 1'b0,
    WTP_POP_FROM_TABLE_OP = 1'b1
  } wtp_op_t;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    WTP_IDLE = 8'h01,
    WTP_HEAD = 8'h02,
    WTP_HEADW = 8'h04,
    WTP_FETCH = 8'h08,
    WTP_FETCHW = 8'h10,
    WTP_PUT = 8'h20,
    WTP_TAIL = 8'h40,
    WTP_DONE = 8'h80
  } wtp_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    wtp_op_t kind;
    logic [WTP_LEN_W-1:0] tableLen;
    logic [WTP_ADDR_W-1:0] tableBase;
    logic [WTP_ADDR_W-1:0] operandAddr;
  } wtp_req_t;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [WTP_ADDR_W-1:0] addr;
    logic [WTP_WORD_W-1:0] wrData;
  } wtp_mem_t;

  typedef struct packed {
    wtp_state_t state;
    wtp_req_t req;
    logic [WTP_WORD_W-1:0] head;
    logic [WTP_WORD_W-1:0] data;
    logic [WTP_LEN_W:0] idx;
    wtp_mem_t mem;
    logic done;
    logic limitFlag;
  } wtp_core_t;

  localparam wtp_core_t WTP_CORE_RST = '{
    state: WTP_IDLE,
    req: '{kind: WTP_STORE_INTO_TABLE_OP, tableLen: 8'h00,
           tableBase: 16'h0000, operandAddr: 16'h0000},
    head: 16'h0000,
    data: 16'h0000,
    idx: 9'h000,
    mem: '{rdEn: 1'b0, wrEn: 1'b0, addr: 16'h0000, wrData: 16'h0000},
    done: 1'b0,
    limitFlag: 1'b0
  };

endpackage

//--- rtl/wtp_table_unit.sv
`timescale 1ns/100ps

// Functional notes
// - Store copies source word to pointed slot, then increments pointer word.
// - Pointer equal to table length wraps to one on the next store.
// - Store treats the table base word as pointer, not data.
// - Each accepted request executes once; no edge detection inside.
// - Store pointer above table length writes no table data.
// - After store, flag set when pointer equals table length.
// - Flag holds until scan end or the next table operation.
// - First data slot written at pointer zero and at pointer equal length.
// - Pop moves top entry to destination and shifts counted entries up.
// - Pop treats base word as count and decrements it on each pop that is not skipped.
// - Pop count zero or above length: skip, move nothing, set flag.
// - After pop, flag set when count equals zero.
// - Slots numbered from top; slots beyond count stay untouched.
module wtp_table_unit
  import wtp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operation request from the sequencer
  input wire logic opValid,
  output logic opReady,
  input wire wtp_req_t opReq,
  output logic opDone,
  // Scan boundary
  input wire logic scanEnd,
  // Word memory port
  output wtp_mem_t memPort,
  input wire logic [WTP_WORD_W-1:0] memRdData,
  // Status
  output logic tableLimitFlag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wtp_core_t core_reg;
  wtp_core_t core_next;

  // ----------------------------------------------------------------
  // Head word checks
  // ----------------------------------------------------------------
  logic [WTP_WORD_W-1:0] lenWord;
  logic headAboveLen;
  logic headAtLen;
  logic [WTP_WORD_W-1:0] rdHead;
  logic popSkip;

  assign lenWord = {{(WTP_WORD_W-WTP_LEN_W){1'b0}}, core_reg.req.tableLen};
  assign rdHead = memRdData;
  // Read data is the head word only while the sequencer waits on it
  assign headAboveLen = rdHead > lenWord;
  assign popSkip = rdHead == WTP_ZERO || headAboveLen;
  assign headAtLen = core_reg.head == lenWord;

  // ----------------------------------------------------------------
  // Address and head arithmetic
  // ----------------------------------------------------------------
  logic storeOp;
  logic headZero;
  logic moreSlots;
  logic storeFlag;
  logic popFlag;
  logic [WTP_WORD_W-1:0] idxWord;
  logic [WTP_LEN_W:0] idxInc;
  logic [WTP_ADDR_W-1:0] slotOne;
  logic [WTP_ADDR_W-1:0] storeSlot;
  logic [WTP_ADDR_W-1:0] popWrAddr;
  logic [WTP_ADDR_W-1:0] popRdAddr;
  logic [WTP_WORD_W-1:0] storeHead;
  logic [WTP_WORD_W-1:0] popHead;

  assign storeOp = core_reg.req.kind == WTP_STORE_INTO_TABLE_OP;
  assign headZero = core_reg.head == WTP_ZERO;
  assign idxWord = {{(WTP_WORD_W-WTP_LEN_W-1){1'b0}}, core_reg.idx};
  assign idxInc = core_reg.idx + {{WTP_LEN_W{1'b0}}, 1'b1};
  // Only counted slots take part in the shift
  assign moreSlots = !storeOp && idxWord < core_reg.head;
  assign slotOne = core_reg.req.tableBase + WTP_FIRST_SLOT;
  // Pointer zero and pointer at length both land in the first slot
  assign storeSlot = (headZero || headAtLen) ? slotOne
                     : core_reg.req.tableBase + core_reg.head + WTP_STEP;
  // Slot one leaves for the destination, slot n moves up to slot n-1
  assign popWrAddr = (idxWord == WTP_FIRST_SLOT) ? core_reg.req.operandAddr
                     : core_reg.req.tableBase + idxWord - WTP_FIRST_SLOT;
  assign popRdAddr = core_reg.req.tableBase + idxWord + WTP_FIRST_SLOT;
  // Wrap to one, never zero
  assign storeHead = headAtLen ? WTP_PTR_WRAP : core_reg.head + WTP_STEP;
  assign popHead = core_reg.head - WTP_STEP;
  assign storeFlag = core_reg.mem.wrData == lenWord;
  assign popFlag = core_reg.mem.wrData == WTP_ZERO;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    core_next = core_reg;
    core_next.mem.rdEn = 1'b0;
    core_next.mem.wrEn = 1'b0;
    core_next.done = 1'b0;
    if (scanEnd) begin
      core_next.limitFlag = 1'b0;
    end
    case (core_reg.state)
      WTP_IDLE: begin
        // Request captured whole; later input changes are ignored
        if (opValid) begin
          core_next.req = opReq;
          core_next.state = WTP_HEAD;
          core_next.mem.rdEn = 1'b1;
          core_next.mem.addr = opReq.tableBase;
        end
      end
      WTP_HEAD: begin
        core_next.state = WTP_HEADW;
      end
      WTP_HEADW: begin
        // Head word arrives from the read issued on the take
        core_next.head = rdHead;
        core_next.idx = 9'h001;
        if (storeOp) begin
          if (headAboveLen) begin
            // Pointer left alone, nothing written
            core_next.state = WTP_DONE;
            core_next.limitFlag = 1'b0;
          end else begin
            core_next.state = WTP_FETCH;
            core_next.mem.rdEn = 1'b1;
            core_next.mem.addr = core_reg.req.operandAddr;
          end
        end else begin
          if (popSkip) begin
            core_next.state = WTP_DONE;
            core_next.limitFlag = 1'b1;
          end else begin
            core_next.state = WTP_FETCH;
            core_next.mem.rdEn = 1'b1;
            core_next.mem.addr = slotOne;
          end
        end
      end
      WTP_FETCH: begin
        core_next.state = WTP_FETCHW;
      end
      WTP_FETCHW: begin
        // Source word for a store, next counted slot for a pop
        core_next.data = memRdData;
        core_next.state = WTP_PUT;
        core_next.mem.wrEn = 1'b1;
        core_next.mem.wrData = memRdData;
        if (storeOp) begin
          core_next.mem.addr = storeSlot;
        end else begin
          core_next.mem.addr = popWrAddr;
        end
      end
      WTP_PUT: begin
        // Fetch the next counted slot, else write the head word back
        if (moreSlots) begin
          core_next.idx = idxInc;
          core_next.state = WTP_FETCH;
          core_next.mem.rdEn = 1'b1;
          core_next.mem.addr = popRdAddr;
        end else begin
          core_next.state = WTP_TAIL;
          core_next.mem.wrEn = 1'b1;
          core_next.mem.addr = core_reg.req.tableBase;
          if (storeOp) begin
            core_next.mem.wrData = storeHead;
          end else begin
            core_next.mem.wrData = popHead;
          end
        end
      end
      WTP_TAIL: begin
        // Result overrides a scan end clear in the same cycle
        core_next.state = WTP_DONE;
        if (storeOp) begin
          core_next.limitFlag = storeFlag;
        end else begin
          core_next.limitFlag = popFlag;
        end
      end
      WTP_DONE: begin
        // Ready and done rise together
        core_next.state = WTP_IDLE;
        core_next.done = 1'b1;
      end
      default: begin
        core_next = WTP_CORE_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      core_reg <= WTP_CORE_RST;
    end else begin
      core_reg <= core_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign opReady = core_reg.state == WTP_IDLE;
  assign opDone = core_reg.done;
  assign memPort = core_reg.mem;
  assign tableLimitFlag = core_reg.limitFlag;

endmodule

//--- test/wtp_table_unit_sva.sv
`timescale 1ns/100ps
module wtp_table_unit_sva
  import wtp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input wire logic opValid,
  input wire logic opReady,
  input wire wtp_req_t opReq,
  input wire logic opDone,
  input wire logic scanEnd,
  input wire wtp_mem_t memPort,
  input wire logic tableLimitFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic take = opValid && opReady;
  // Busy cycles since the take; a full 255 slot pop stays busy 769 cycles
  logic [9:0] busyCnt;
  always_ff @(posedge mclk) begin
    if (rst || opReady) begin
      busyCnt <= 10'h000;
    end else begin
      busyCnt <= busyCnt + 10'h001;
    end
  end
  chk_take_busy: assert property (take |=> !opReady)
    else $error("ready high after take");
  chk_busy_hold: assert property (!opReady |=> !opReady || opDone)
    else $error("ready rose before done");
  chk_done_idle: assert property (opDone |-> opReady ##1 !opDone)
    else $error("done not single or not idle");
  chk_head_read: assert property (take |=> memPort.rdEn && memPort.addr == $past(opReq.tableBase))
    else $error("head word not read first");
  chk_store_time: assert property (take && opReq.kind == WTP_STORE_INTO_TABLE_OP |-> ##[4:9] opDone)
    else $error("store too slow");
  chk_pop_time: assert property (!opReady |-> busyCnt <= 10'h300)
    else $error("pop too slow");
  chk_scan_clear: assert property (scanEnd && opReady |=> !tableLimitFlag)
    else $error("flag not cleared at scan end");
  chk_flag_hold: assert property (opReady && !scanEnd |=> $stable(tableLimitFlag))
    else $error("flag moved while idle");
endmodule

//--- test/wtp_mem_model.sv
`timescale 1ns/100ps
module wtp_mem_model
  import wtp_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Memory port
  input wire wtp_mem_t memPort,
  output logic [WTP_WORD_W-1:0] memRdData
);
  logic [WTP_WORD_W-1:0] mem [0:255];
  logic [WTP_WORD_W-1:0] rdQ;
  logic rdVal;
  always @(posedge mclk) begin
    rdVal <= memPort.rdEn;
    if (memPort.rdEn) rdQ <= mem[memPort.addr[7:0]];
    if (memPort.wrEn) mem[memPort.addr[7:0]] <= memPort.wrData;
  end
  // Data valid one cycle only
  assign memRdData = rdVal ? rdQ : ~rdQ;
endmodule

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
  import wtp_pkg::*;
  logic mclk, rst, opValid, scanEnd, opReady, opDone, tableLimitFlag;
  wtp_req_t opReq;
  wtp_mem_t memPort;
  logic [WTP_WORD_W-1:0] memRdData;
  logic [15:0] refMem [0:255];
  logic [15:0] notes [$];
  logic [31:0] rng = 32'h00012DDE;
  int errorCnt, checkCount, cyc;
  wtp_table_unit wtp_table_unit_i (.mclk(mclk), .rst(rst), .opValid(opValid),
    .opReady(opReady), .opReq(opReq), .opDone(opDone), .scanEnd(scanEnd),
    .memPort(memPort), .memRdData(memRdData), .tableLimitFlag(tableLimitFlag));
  wtp_mem_model wtp_mem_model_i (.mclk(mclk), .memPort(memPort), .memRdData(memRdData));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (errorCnt == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic put(input logic [15:0] a, input logic [15:0] v);
    refMem[a[7:0]] = v;
    wtp_mem_model_i.mem[a[7:0]] = v;
  endtask
  // Held valid between calls, so repeats run back to back
  task automatic run(input wtp_op_t k, input logic [7:0] n, input logic [15:0] b, d);
    logic [15:0] c;
    logic f;
    @(negedge mclk);
    while (!opReady) @(negedge mclk);
    opReq = '{k, n, b, d};
    opValid = 1'b1;
    // Model moves after the take, clear of the result watcher
    @(negedge mclk);
    c = refMem[b];
    f = 1'b1;
    if (k == WTP_STORE_INTO_TABLE_OP) begin
      f = 1'b0;
      if (c <= n) begin
        refMem[(c == 0 || c == n) ? b + 1 : b + c + 1] = refMem[d];
        refMem[b] = (c == n) ? 16'h0001 : c + 16'h0001;
        f = refMem[b] == n;
      end
    end else if (c != 0 && c <= n) begin
      refMem[d] = refMem[b + 1];
      for (int i = 2; i <= c; i++) refMem[b + i - 1] = refMem[b + i];
      refMem[b] = c - 16'h0001;
      f = c == 1;
    end
    notes.push_back({15'h0000, f});
  endtask
  task automatic idle();
    @(negedge mclk);
    while (!opReady) @(negedge mclk);
    opValid = 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(negedge mclk) begin
    if (opDone === 1'b1) begin
      check("flag", {15'h0000, tableLimitFlag}, notes.pop_front());
      for (int a = 0; a < 256; a++) check("word", wtp_mem_model_i.mem[a], refMem[a]);
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      summarize();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    opValid = 1'b0;
    scanEnd = 1'b0;
    opReq = '0;
    for (int a = 0; a < 256; a++) begin
      rng = xs(rng);
      put(16'(a), rng[15:0]);
    end
    put(16'h0010, 16'h0000);
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (8) run(WTP_STORE_INTO_TABLE_OP, 8'h06, 16'h0010, 16'h0080);
    idle();
    put(16'h0010, 16'h0009);
    put(16'h0030, 16'h0004);
    run(WTP_STORE_INTO_TABLE_OP, 8'h06, 16'h0010, 16'h0080);
    repeat (5) run(WTP_POP_FROM_TABLE_OP, 8'h06, 16'h0030, 16'h0081);
    idle();
    put(16'h0030, 16'h0007);
    run(WTP_POP_FROM_TABLE_OP, 8'h06, 16'h0030, 16'h0081);
    idle();
    scanEnd = 1'b1;
    @(negedge mclk);
    scanEnd = 1'b0;
    check("flag", {15'h0000, tableLimitFlag}, 16'h0000);
    repeat (20) begin
      rng = xs(rng);
      put(16'h0040, {12'h000, rng[7:4]});
      put(16'h00A0, rng[31:16]);
      run(wtp_op_t'(rng[8]), {4'h0, rng[3:0]}, 16'h0040, 16'h00A0);
      run(wtp_op_t'(rng[9]), {4'h0, rng[3:0]}, 16'h0040, 16'h00A0);
      idle();
    end
    summarize();
  end
endmodule

bind wtp_table_unit wtp_table_unit_sva wtp_table_unit_sva_i (.mclk(mclk), .rst(rst),
  .opValid(opValid), .opReady(opReady), .opReq(opReq), .opDone(opDone),
  .scanEnd(scanEnd), .memPort(memPort), .tableLimitFlag(tableLimitFlag));
